// ===== rtl/cmpc_pkg.sv
package cmpc_pkg;

    // Boot source chosen for one configuration sequence
    typedef enum logic [1:0] {
        CMPC_SRC_NONE = 2'h0,
        CMPC_SRC_SPI = 2'h1,
        CMPC_SRC_FLASH = 2'h2
    } cmpc_src_t;

    // Timing: configuration clock tail after wake-up, cycles of the config clock
    localparam int CMPC_TAIL_MIN = 100;
    localparam int CMPC_TAIL_MAX = 500;
    localparam int CMPC_TAIL_DEFAULT = 256;
    // SRAM initialisation time in ns, and its cycle count at 100 MHz (rounded up)
    localparam int CMPC_CLK_PERIOD_NS = 10;
    localparam int CMPC_INIT_TIME_NS = 1000;
    localparam int CMPC_INIT_CYCLES = (CMPC_INIT_TIME_NS + CMPC_CLK_PERIOD_NS - 1)
        / CMPC_CLK_PERIOD_NS;

    localparam logic CMPC_DONE_ACTIVE_RESET = 1'b0;

    // Loader request/result carried as one group
    typedef struct packed {
        logic start;
        cmpc_src_t src;
    } cmpc_load_req_t;

    typedef struct packed {
        logic ok;
        logic fail;
        logic crc_err;
    } cmpc_load_rsp_t;

    // Open-drain/two-way pin drive as two signals (o, oe)
    typedef struct packed {
        logic o;
        logic oe;
    } cmpc_pin_drv_t;

endpackage : cmpc_pkg

// ===== rtl/cmpc_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - Low select high boots only from on-chip flash, high select ignored.
// - Both selects low: try SPI first, fall back to flash if image present.
// - Low select low, high select high: flash if image present, else SPI; no fallback.
// - Power-on reset or request low enters configuration by mode pins.
// - Falling request edge starts configuration when not under JTAG and low select low.
// - Under JTAG control the request pin is ignored.
// - Request, init and complete pins dedicated only when low select low.
// - High select freed as user I/O when low select high.
// - Init held low during SRAM initialisation, released when ready.
// - External low on init postpones configuration.
// - CRC mismatch drives init low, keeps complete low, no wake-up.
// - Self flash boot neither drives nor monitors init.
// - Direct programming error blocks flash boot except in self flash boot; background error harmless.
// - Complete pin open-drain by default, active drive by option.
// - Complete driven low while configuring and completion bit unset.
// - Init and request high with bit set: release or drive complete.
// - External low on complete holds device non-functional if selected.
// - Under JTAG configuration complete follows its boundary-scan cell.
// - Unused dual-purpose pins tri-state with pull-up until user mode.
// - Config clock runs 100 to 500 cycles after wake-up from an SPI load, then stops.
module cmpc_ctrl
    import cmpc_pkg::*;
#(
    parameter int INIT_CYCLES = CMPC_INIT_CYCLES,
    parameter int TAIL_CYCLES = CMPC_TAIL_DEFAULT
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic boot_select_lo_i,
    input wire logic boot_select_hi_i,
    input wire logic reconfig_request_n_i,
    input wire logic init_status_n_i,
    output logic init_status_n_o,
    output logic init_status_n_oe_o,
    input wire logic config_complete_i,
    output logic config_complete_o,
    output logic config_complete_oe_o,
    input wire logic jtag_active_i,
    input wire logic jtag_done_bscan_i,
    input wire logic done_active_drive_i,
    input wire logic wake_wait_done_i,
    input wire logic flash_image_valid_i,
    input wire logic flash_direct_error_i,
    input wire logic flash_background_error_i,
    output cmpc_load_req_t load_req_o,
    input wire cmpc_load_rsp_t load_rsp_i,
    output logic config_clock_pin_en_o,
    output logic sram_init_o,
    output logic user_mode_o,
    output logic config_pins_user_o,
    output logic select_hi_user_o,
    output logic user_io_tristate_o,
    output logic busy_o
);

    typedef enum logic [6:0] {
        CMPC_ST_IDLE = 7'h01,
        CMPC_ST_INIT = 7'h02,
        CMPC_ST_WAIT = 7'h04,
        CMPC_ST_LOAD = 7'h08,
        CMPC_ST_WAKE = 7'h10,
        CMPC_ST_USER = 7'h20,
        CMPC_ST_ERR = 7'h40
    } cmpc_state_t;

    localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);
    localparam logic [9:0] TAIL_LAST = 10'(TAIL_CYCLES - 1);

    cmpc_state_t state_reg;
    cmpc_state_t state_next;
    logic req_dly_reg;
    logic por_pend_reg;
    logic sdm_reg;
    logic hi_reg;
    logic second_try_reg;
    logic done_bit_reg;
    logic flash_block_reg;
    logic [15:0] init_cnt_reg;
    logic [9:0] tail_cnt_reg;
    logic tail_run_reg;
    cmpc_load_req_t load_req_reg;
    logic start_seq;
    logic req_fall;
    cmpc_src_t first_src;
    cmpc_src_t second_src;
    logic flash_ok;
    logic sdm_now;

    assign req_fall = req_dly_reg & ~reconfig_request_n_i;
    // request honoured only outside JTAG and when pin is dedicated
    assign start_seq = por_pend_reg
        | (req_fall & ~jtag_active_i & ~boot_select_lo_i & state_reg != CMPC_ST_IDLE);
    assign flash_ok = flash_image_valid_i & ~flash_block_reg;
    // Mode as seen from the start edge on, so SELF_FLASH_BOOT never drives init for even one cycle
    assign sdm_now = start_seq ? boot_select_lo_i : sdm_reg;

    always_comb begin
        if (sdm_reg) begin
            first_src = CMPC_SRC_FLASH;
            second_src = CMPC_SRC_NONE;
        end else if (hi_reg) begin
            first_src = flash_ok ? CMPC_SRC_FLASH : CMPC_SRC_SPI;
            second_src = CMPC_SRC_NONE;
        end else begin
            first_src = CMPC_SRC_SPI;
            second_src = flash_ok ? CMPC_SRC_FLASH : CMPC_SRC_NONE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_dly_reg <= 1'b1;
        end else begin
            req_dly_reg <= reconfig_request_n_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            por_pend_reg <= 1'b1;
        end else begin
            por_pend_reg <= 1'b0;
        end
    end

    // Mode pins latched once at sequence start
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdm_reg <= 1'b0;
            hi_reg <= 1'b0;
        end else if (start_seq) begin
            sdm_reg <= boot_select_lo_i;
            hi_reg <= boot_select_hi_i & ~boot_select_lo_i;
        end
    end

    // Direct programming error blocks flash except in self flash boot; background error input is not used
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flash_block_reg <= 1'b0;
        end else if (flash_direct_error_i && state_reg != CMPC_ST_USER) begin
            flash_block_reg <= 1'b1;
        end else if (flash_image_valid_i && !flash_direct_error_i && state_reg == CMPC_ST_IDLE) begin
            flash_block_reg <= 1'b0;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CMPC_ST_IDLE: begin
                state_next = CMPC_ST_IDLE;
            end
            CMPC_ST_INIT: begin
                if (init_cnt_reg == INIT_LAST && reconfig_request_n_i) begin
                    state_next = sdm_reg ? CMPC_ST_LOAD : CMPC_ST_WAIT;
                end
            end
            CMPC_ST_WAIT: begin
                if (init_status_n_i) begin
                    state_next = CMPC_ST_LOAD;
                end
            end
            CMPC_ST_LOAD: begin
                if (load_rsp_i.crc_err) begin
                    state_next = CMPC_ST_ERR;
                end else if (load_rsp_i.ok) begin
                    state_next = CMPC_ST_WAKE;
                end
            end
            CMPC_ST_WAKE: begin
                // optional hold while complete pin is pulled low externally
                if (!wake_wait_done_i || config_complete_i || sdm_reg) begin
                    state_next = CMPC_ST_USER;
                end
            end
            CMPC_ST_USER: begin
                state_next = CMPC_ST_USER;
            end
            CMPC_ST_ERR: begin
                state_next = CMPC_ST_ERR;
            end
            default: begin
                state_next = CMPC_ST_IDLE;
            end
        endcase
        if (start_seq) begin
            state_next = CMPC_ST_INIT;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= CMPC_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_cnt_reg <= 16'h0000;
        end else if (state_reg != CMPC_ST_INIT || start_seq) begin
            init_cnt_reg <= 16'h0000;
        end else if (init_cnt_reg != INIT_LAST) begin
            init_cnt_reg <= init_cnt_reg + 16'h0001;
        end
    end

    // Loader request: first source, one fallback try on failure
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_req_reg <= '0;
            second_try_reg <= 1'b0;
        end else begin
            load_req_reg.start <= 1'b0;
            if (state_reg != CMPC_ST_LOAD && state_next == CMPC_ST_LOAD) begin
                load_req_reg.start <= 1'b1;
                load_req_reg.src <= first_src;
                second_try_reg <= 1'b0;
            end else if (state_reg == CMPC_ST_LOAD && load_rsp_i.fail && !second_try_reg
                    && second_src != CMPC_SRC_NONE) begin
                load_req_reg.start <= 1'b1;
                load_req_reg.src <= second_src;
                second_try_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_bit_reg <= 1'b0;
        end else if (start_seq) begin
            done_bit_reg <= 1'b0;
        end else if (state_reg == CMPC_ST_LOAD && load_rsp_i.ok && !load_rsp_i.crc_err) begin
            done_bit_reg <= 1'b1;
        end
    end

    // Config clock tail after wake-up in master SPI loads
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tail_cnt_reg <= 10'h000;
            tail_run_reg <= 1'b0;
        end else if (start_seq) begin
            tail_cnt_reg <= 10'h000;
            tail_run_reg <= 1'b0;
        end else if (state_reg == CMPC_ST_WAKE && state_next == CMPC_ST_USER
                && load_req_reg.src == CMPC_SRC_SPI) begin
            tail_run_reg <= 1'b1;
        end else if (tail_run_reg) begin
            if (tail_cnt_reg == TAIL_LAST) begin
                tail_run_reg <= 1'b0;
            end else begin
                tail_cnt_reg <= tail_cnt_reg + 10'h001;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_status_n_o <= 1'b0;
            init_status_n_oe_o <= 1'b0;
            config_complete_o <= 1'b0;
            config_complete_oe_o <= 1'b0;
            config_clock_pin_en_o <= 1'b0;
        end else begin
            init_status_n_o <= 1'b0;
            // pull init low in init and on CRC error, never in SELF_FLASH_BOOT
            init_status_n_oe_o <= ~sdm_now & (state_next == CMPC_ST_INIT
                | state_next == CMPC_ST_ERR);
            if (jtag_active_i) begin
                config_complete_o <= jtag_done_bscan_i;
                config_complete_oe_o <= 1'b1;
            end else if (sdm_now || state_next == CMPC_ST_IDLE) begin
                config_complete_o <= 1'b0;
                config_complete_oe_o <= 1'b0;
            end else if (done_bit_reg && init_status_n_i && reconfig_request_n_i
                    && state_next != CMPC_ST_ERR) begin
                config_complete_o <= done_active_drive_i;
                config_complete_oe_o <= done_active_drive_i;
            end else begin
                config_complete_o <= 1'b0;
                config_complete_oe_o <= 1'b1;
            end
            config_clock_pin_en_o <= (state_next == CMPC_ST_LOAD
                & load_req_reg.src == CMPC_SRC_SPI) | tail_run_reg;
        end
    end

    assign load_req_o = load_req_reg;
    assign sram_init_o = (state_reg == CMPC_ST_INIT);
    assign user_mode_o = (state_reg == CMPC_ST_USER);
    assign config_pins_user_o = boot_select_lo_i;
    assign select_hi_user_o = boot_select_lo_i;
    assign user_io_tristate_o = (state_reg != CMPC_ST_USER);
    assign busy_o = (state_reg != CMPC_ST_USER) && (state_reg != CMPC_ST_IDLE);

    a_crc_err_init: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == CMPC_ST_ERR && !sdm_reg) |-> init_status_n_oe_o && !init_status_n_o)
        else $error("init not low after CRC error");
    a_sdm_no_init: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        sdm_reg |-> !init_status_n_oe_o)
        else $error("init driven in self flash boot");
    a_wait_init: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == CMPC_ST_WAIT && !init_status_n_i && !start_seq)
        |=> state_reg == CMPC_ST_WAIT)
        else $error("left wait while init held low");
    a_jtag_ignore: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (jtag_active_i && !por_pend_reg) |-> !start_seq)
        else $error("request honoured under JTAG");
    a_req_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (req_fall && !jtag_active_i && !boot_select_lo_i && state_reg != CMPC_ST_IDLE)
        |=> state_reg == CMPC_ST_INIT)
        else $error("request edge did not start configuration");
    a_sdm_src: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (load_req_o.start && sdm_reg) |-> load_req_o.src == CMPC_SRC_FLASH)
        else $error("self flash boot used another source");
    a_done_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!jtag_active_i && $past(!jtag_active_i) && state_reg == CMPC_ST_LOAD && !sdm_reg
        && !done_bit_reg) |-> config_complete_oe_o && !config_complete_o)
        else $error("complete not low during configuration");
    a_err_stuck: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == CMPC_ST_ERR && !start_seq) |=> !user_mode_o)
        else $error("woke up after CRC error");
    a_flash_block: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (load_req_o.start && $past(flash_block_reg) && !sdm_reg)
        |-> load_req_o.src == CMPC_SRC_SPI)
        else $error("blocked flash image used");
    a_tail_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == CMPC_ST_USER && !tail_run_reg) |=> !config_clock_pin_en_o)
        else $error("config clock runs after its tail");
    a_done_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == CMPC_ST_USER && !sdm_reg && !jtag_active_i && init_status_n_i
        && reconfig_request_n_i) |=> config_complete_oe_o == $past(done_active_drive_i))
        else $error("complete not released in user mode");

endmodule : cmpc_ctrl

// ===== tb/cmpc_partner.sv
`timescale 1ns/100ps
module cmpc_partner
    import cmpc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire cmpc_load_req_t load_req_i,
    input wire logic [1:0] spi_code_i,
    input wire logic [1:0] flash_code_i,
    input wire logic [3:0] delay_i,
    input wire logic init_oe_i,
    input wire logic done_o_i,
    input wire logic done_oe_i,
    input wire logic hold_init_i,
    input wire logic hold_done_i,
    output cmpc_load_rsp_t load_rsp_o,
    output logic init_wire_o,
    output logic done_wire_o
);
    int cnt;
    logic [1:0] code;

    // Open-drain lines with weak pull-up; the board may hold either low
    assign init_wire_o = !init_oe_i && !hold_init_i;
    assign done_wire_o = (done_oe_i ? done_o_i : 1'b1) && !hold_done_i;

    // Loader answers after a chosen delay: code 0 ok, 1 fail, 2 checksum error
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= -1;
            code <= 2'h0;
            load_rsp_o <= '0;
        end else begin
            load_rsp_o <= '0;
            if (load_req_i.start) begin
                code <= (load_req_i.src == CMPC_SRC_SPI) ? spi_code_i : flash_code_i;
                cnt <= int'(delay_i);
            end else if (cnt == 0) begin
                load_rsp_o <= '{ok: code == 2'h0, fail: code == 2'h1, crc_err: code == 2'h2};
                cnt <= -1;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : cmpc_partner

// ===== tb/tb_config_mode_pin_control.sv
`timescale 1ns/100ps
module tb_config_mode_pin_control;
    import cmpc_pkg::*;
    logic clk = 0, rst_n = 0, lo = 0, hi = 0, req_n = 1, jtag = 0, act = 0, wwait = 0, img = 0;
    logic hold_init = 0, hold_done = 0, init_w, done_w, init_o, init_oe, done_o, done_oe;
    logic derr = 0, bscan = 0;
    logic clk_en, sram_init, user, pins_user, hi_user, tri_st, busy, init_drv, done_low;
    logic [1:0] spi_code = 2'h0, flash_code = 2'h0;
    logic [3:0] dly = 4'h0;
    cmpc_load_req_t load_req;
    cmpc_load_rsp_t load_rsp;
    cmpc_src_t seen[$];
    int fails = 0, n_tests = 0;

    cmpc_ctrl #(.INIT_CYCLES(4), .TAIL_CYCLES(100)) u_cmpc_ctrl (
        .ref_clk_i(clk), .rst_n_i(rst_n), .boot_select_lo_i(lo), .boot_select_hi_i(hi),
        .reconfig_request_n_i(req_n), .init_status_n_i(init_w), .init_status_n_o(init_o),
        .init_status_n_oe_o(init_oe), .config_complete_i(done_w), .config_complete_o(done_o),
        .config_complete_oe_o(done_oe), .jtag_active_i(jtag), .jtag_done_bscan_i(bscan),
        .done_active_drive_i(act), .wake_wait_done_i(wwait), .flash_image_valid_i(img),
        .flash_direct_error_i(derr), .flash_background_error_i(1'b0), .load_req_o(load_req),
        .load_rsp_i(load_rsp), .config_clock_pin_en_o(clk_en), .sram_init_o(sram_init),
        .user_mode_o(user), .config_pins_user_o(pins_user), .select_hi_user_o(hi_user),
        .user_io_tristate_o(tri_st), .busy_o(busy));

    cmpc_partner u_cmpc_partner (
        .ref_clk_i(clk), .rst_n_i(rst_n), .load_req_i(load_req), .spi_code_i(spi_code),
        .flash_code_i(flash_code), .delay_i(dly), .init_oe_i(init_oe), .done_o_i(done_o),
        .done_oe_i(done_oe), .hold_init_i(hold_init), .hold_done_i(hold_done),
        .load_rsp_o(load_rsp), .init_wire_o(init_w), .done_wire_o(done_w));

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (load_req.start === 1'b1) seen.push_back(load_req.src);
        if (init_oe === 1'b1) init_drv <= 1'b1;
        if (done_oe === 1'b1 && done_o === 1'b0 && !lo) done_low <= 1'b1;
    end

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_src(input string name, input cmpc_src_t exp, input cmpc_src_t got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk_src

    // One configuration sequence; hold 1 keeps init low, hold 2 keeps complete low
    task automatic boot(input logic l, h, im, input logic [1:0] sc, fc, input bit by_req,
                        input int hold);
        cmpc_src_t exp[$];
        cmpc_src_t last;
        logic [1:0] code;
        @(negedge clk);
        lo = l;
        hi = h;
        img = im;
        spi_code = sc;
        flash_code = fc;
        act = 1'($urandom_range(1));
        dly = 4'($urandom_range(15));
        hold_init = (hold == 1);
        hold_done = (hold == 2);
        wwait = (hold == 2);
        seen.delete();
        init_drv = 1'b0;
        done_low = 1'b0;
        if (by_req) req_n = 1'b0;
        else rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        req_n = 1'b1;
        if (hold == 1) begin
            repeat (40) @(negedge clk);
            chk_bit("postponed", 1'b1, seen.size() == 0);
            hold_init = 1'b0;
        end
        repeat (80) @(negedge clk);
        if (hold == 2) begin
            chk_bit("held asleep", 1'b0, user);
            hold_done = 1'b0;
            repeat (20) @(negedge clk);
        end
        exp.push_back((l || (h && im && !derr)) ? CMPC_SRC_FLASH : CMPC_SRC_SPI);
        if (!l && !h && sc == 2'h1 && im && !derr) exp.push_back(CMPC_SRC_FLASH);
        last = exp[exp.size() - 1];
        code = (last == CMPC_SRC_SPI) ? sc : fc;
        chk_bit("request count", 1'b1, seen.size() == exp.size());
        foreach (exp[k]) chk_src("boot source", exp[k], seen[k]);
        chk_bit("init driven", !l, init_drv);
        chk_bit("complete low", !l, done_low);
        chk_bit("user mode", code == 2'h0, user);
        chk_bit("init error", !l && code == 2'h2, init_oe);
        if (!l) chk_bit("complete wire", code == 2'h0, done_w);
        chk_bit("pins user", l, pins_user);
        chk_bit("select user", l, hi_user);
        chk_bit("complete oe", !l && (code != 2'h0 || act), done_oe);
        chk_bit("io tristate", code != 2'h0, tri_st);
        chk_bit("busy", code != 2'h0, busy);
        chk_bit("sram init", 1'b0, sram_init);
        chk_bit("clock tail", last == CMPC_SRC_SPI && code != 2'h2, clk_en);
        repeat (120) @(negedge clk);
        chk_bit("clock stopped", last == CMPC_SRC_SPI && code == 2'h1, clk_en);
    endtask : boot

    task automatic wrap_up();
        if (fails == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    initial begin
        #500000;
        fails++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'hA67F));
        boot(1'b0, 1'b0, 1'b1, 2'h0, 2'h0, 1'b0, 0);
        boot(1'b0, 1'b0, 1'b1, 2'h1, 2'h0, 1'b0, 0);
        boot(1'b0, 1'b0, 1'b0, 2'h1, 2'h0, 1'b0, 0);
        boot(1'b0, 1'b1, 1'b1, 2'h1, 2'h0, 1'b0, 0);
        boot(1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 1'b0, 0);
        boot(1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 1'b0, 0);
        boot(1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 1'b0, 0);
        boot(1'b0, 1'b0, 1'b1, 2'h2, 2'h0, 1'b0, 0);
        boot(1'b0, 1'b1, 1'b1, 2'h0, 2'h2, 1'b0, 0);
        boot(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1);
        boot(1'b0, 1'b1, 1'b1, 2'h0, 2'h0, 1'b0, 2);
        @(negedge clk);
        seen.delete();
        jtag = 1'b1;
        bscan = 1'($urandom_range(1));
        req_n = 1'b0;
        repeat (20) @(negedge clk);
        chk_bit("jtag ignores request", 1'b1, seen.size() == 0);
        chk_bit("jtag complete", bscan, done_w);
        chk_bit("jtag keeps user", 1'b1, user);
        req_n = 1'b1;
        repeat (5) @(negedge clk);
        jtag = 1'b0;
        boot(1'b0, 1'b0, 1'b1, 2'h0, 2'h0, 1'b1, 0);
        derr = 1'b1;
        boot(1'b0, 1'b1, 1'b1, 2'h0, 2'h0, 1'b1, 0);
        derr = 1'b0;
        repeat (6) begin
            boot(1'($urandom_range(1)), 1'($urandom_range(1)), 1'($urandom_range(1)),
                 2'($urandom_range(2)), 2'h0, 1'b0, 0);
        end
        wrap_up();
    end
endmodule : tb_config_mode_pin_control
